// ===== vkc_top.sv
// Behaviour
// - format field picks input video layout
// - polarity zero: key high selects converters
// - polarity one: key high selects analogue inputs
// - chroma bit: two's complement or offset UV
// - mode 000 external key, 100 byte compare
// - mode 101 two bytes, both pixel edges
// - 110 two, 111 three bytes, rising edges
// - key delayed zero to seven pixel clocks
// - one key byte serves every compare mode
// - control reset clears every control bit
// - pipeline 20 cycles YUV, 12 RGB
// - answer address 1011111, write only
// - key gate lets keying steer mixer
// - multi-byte key needs every byte equal
`timescale 1ns/1ps
`default_nettype none

module vkc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  // fill side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // drain side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign in_ready_out  = (wr_ptr_ff - rd_ptr_ff) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_ptr_ff != rd_ptr_ff;
  assign out_data_out  = mem_ff[rd_ptr_ff[AW-1:0]];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // storage, no reset needed on data
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_in;
    end
  end

  // pointers
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule : vkc_fifo

module vkc_top (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        control_clear_n_in,
  // serial control bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // video input pins
  input  wire logic        video_sample_clock_in,
  input  wire logic        href_in,
  input  wire logic [7:0]  yuv_in,
  input  wire logic [7:0]  uv_in,
  // keying pins
  input  wire logic        pixel_clock_in,
  input  wire logic [7:0]  pixel_in,
  input  wire logic        external_key_in,
  // converter side
  output logic [15:0]      dac_word_out,
  output logic             dac_valid_out,
  input  wire logic        dac_ready_in,
  output logic             video_accept_out,
  output logic [1:0]       video_format_sel_out,
  output logic             mixer_sel_ext_out
);
  localparam int SW = 31; // seven single pins plus three byte buses
  logic [SW-1:0] sync1_ff, sync2_ff;
  logic scl_s, sda_s, pclk_s, vsmp_s, href_s, ekey_s, clr_n_s;
  logic [7:0] pix_s, yuv_s, uv_s;
  logic scl_q_ff, sda_q_ff, pclk_q_ff, vsmp_q_ff, href_q_ff;
  logic scl_rise, scl_fall, start_c, stop_c, pclk_rise, pclk_fall, vsmp_rise;

  // every bus, video, keying and clear pin is asynchronous: two flops before use
  // reset to idle levels so no false bus edge or clear follows reset
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_ff <= {3'h7, 28'h0000000};
      sync2_ff <= {3'h7, 28'h0000000};
    end else begin
      sync1_ff <= {control_clear_n_in, scl_in, sda_in, pixel_clock_in, video_sample_clock_in,
                   href_in, external_key_in, pixel_in, yuv_in, uv_in};
      sync2_ff <= sync1_ff;
    end
  end
  assign {clr_n_s, scl_s, sda_s, pclk_s, vsmp_s, href_s, ekey_s, pix_s, yuv_s, uv_s} = sync2_ff;

  // previous values for edge detection
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      {scl_q_ff, sda_q_ff} <= 2'h3;
      {pclk_q_ff, vsmp_q_ff, href_q_ff} <= 3'h0;
    end else begin
      {scl_q_ff, sda_q_ff} <= {scl_s, sda_s};
      {pclk_q_ff, vsmp_q_ff, href_q_ff} <= {pclk_s, vsmp_s, href_s};
    end
  end
  assign scl_rise  = scl_s & ~scl_q_ff;
  assign scl_fall  = ~scl_s & scl_q_ff;
  assign start_c   = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_c    = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign pclk_rise = pclk_s & ~pclk_q_ff;
  assign pclk_fall = ~pclk_s & pclk_q_ff;
  assign vsmp_rise = vsmp_s & ~vsmp_q_ff;

  // serial bus slave
  vkc_pkg::vkc_state_t state_ff;
  logic [7:0] shift_ff, sub_ff, pend_data_ff, pend_sub_ff;
  logic [3:0] bit_cnt_ff;
  logic       ack_ff, pend_ff;
  logic       commit;
  logic [7:0] mode_reg_ff, delay_reg_ff, key_reg_ff;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff   <= vkc_pkg::ST_IDLE;
      shift_ff   <= 8'h00;
      bit_cnt_ff <= 4'h0;
      ack_ff     <= 1'b0;
      sub_ff     <= 8'h00;
    end else if (start_c) begin
      state_ff   <= vkc_pkg::ST_ADDR;
      bit_cnt_ff <= 4'h0;
      ack_ff     <= 1'b0;
    end else if (stop_c) begin
      state_ff <= vkc_pkg::ST_IDLE;
      ack_ff   <= 1'b0;
    end else begin
      case (state_ff)
        vkc_pkg::ST_ADDR, vkc_pkg::ST_SUB, vkc_pkg::ST_DATA: begin
          if (scl_rise) begin
            shift_ff   <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            if (state_ff == vkc_pkg::ST_ADDR) begin
              // read direction or other address: no acknowledge
              if (shift_ff == {vkc_pkg::I2C_ADDR, 1'b0}) begin
                state_ff <= vkc_pkg::ST_ACKA;
                ack_ff   <= 1'b1;
              end else begin
                state_ff <= vkc_pkg::ST_SKIP;
              end
            end else if (state_ff == vkc_pkg::ST_SUB) begin
              sub_ff   <= shift_ff;
              state_ff <= vkc_pkg::ST_ACKS;
              ack_ff   <= 1'b1;
            end else begin
              state_ff <= vkc_pkg::ST_ACKD;
              ack_ff   <= 1'b1;
            end
          end
        end
        vkc_pkg::ST_ACKA: if (scl_fall) begin
          ack_ff   <= 1'b0;
          state_ff <= vkc_pkg::ST_SUB;
        end
        vkc_pkg::ST_ACKS: if (scl_fall) begin
          ack_ff   <= 1'b0;
          state_ff <= vkc_pkg::ST_DATA;
        end
        // one data byte per transfer, the rest is ignored
        vkc_pkg::ST_ACKD: if (scl_fall) begin
          ack_ff   <= 1'b0;
          state_ff <= vkc_pkg::ST_SKIP;
        end
        vkc_pkg::ST_IDLE, vkc_pkg::ST_SKIP: ack_ff <= 1'b0;
        default: begin
          state_ff <= vkc_pkg::ST_IDLE;
          ack_ff   <= 1'b0;
        end
      endcase
    end
  end
  assign sda_out    = 1'b0;
  assign sda_oe_out = ack_ff;

  // byte waits for a pixel clock edge before it lands
  assign commit = pend_ff & pclk_rise;
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pend_ff      <= 1'b0;
      pend_data_ff <= 8'h00;
      pend_sub_ff  <= 8'h00;
    end else if (state_ff == vkc_pkg::ST_ACKD && scl_fall) begin
      pend_ff      <= 1'b1; // new byte wins over commit
      pend_data_ff <= shift_ff;
      pend_sub_ff  <= sub_ff;
    end else if (commit || !clr_n_s) begin
      pend_ff <= 1'b0;
    end
  end

  // control registers, write only
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_reg_ff  <= vkc_pkg::REG_RESET;
      delay_reg_ff <= vkc_pkg::REG_RESET;
      key_reg_ff   <= vkc_pkg::REG_RESET;
    end else if (!clr_n_s) begin
      mode_reg_ff  <= vkc_pkg::REG_RESET;
      delay_reg_ff <= vkc_pkg::REG_RESET;
      key_reg_ff   <= vkc_pkg::REG_RESET;
    end else if (commit) begin
      case (pend_sub_ff)
        vkc_pkg::SUB_MODE:  mode_reg_ff  <= pend_data_ff;
        vkc_pkg::SUB_DELAY: delay_reg_ff <= pend_data_ff & vkc_pkg::DELAY_MASK;
        vkc_pkg::SUB_KEY:   key_reg_ff   <= pend_data_ff;
        default: ;
      endcase
    end
  end

  logic [1:0] video_format_sel;
  logic       key_polarity_sel, key_gate_on, chroma_code_sel;
  logic [2:0] key_mode_sel, key_delay_cycles;
  logic [7:0] color_key_value;
  assign video_format_sel = mode_reg_ff[vkc_pkg::FMT_LSB +: 2];
  assign key_polarity_sel = mode_reg_ff[vkc_pkg::POL_BIT];
  assign key_gate_on      = mode_reg_ff[vkc_pkg::GATE_BIT];
  assign chroma_code_sel  = mode_reg_ff[vkc_pkg::CHROMA_BIT];
  assign key_mode_sel     = mode_reg_ff[vkc_pkg::KMODE_LSB +: 3];
  assign key_delay_cycles = delay_reg_ff[vkc_pkg::DELAY_LSB +: 3];
  assign color_key_value  = key_reg_ff;
  assign video_format_sel_out = video_format_sel;

  // video capture: uv made offset binary, rgb bypassed
  logic [16:0] pipe_ff [vkc_pkg::PIPE_YUV];
  logic [7:0]  uv_fix;
  logic [16:0] tap;
  logic        push_ff;
  always_comb begin
    uv_fix = uv_s;
    if (video_format_sel != vkc_pkg::FMT_RGB565 && !chroma_code_sel) begin
      uv_fix = {~uv_s[7], uv_s[6:0]};
    end
  end

  // fixed delay line on video clock edges; blanked words carry no valid
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < vkc_pkg::PIPE_YUV; i++) pipe_ff[i] <= '0;
      push_ff <= 1'b0;
    end else begin
      push_ff <= vsmp_rise;
      if (vsmp_rise) begin
        pipe_ff[0] <= {href_s, uv_fix, yuv_s};
        for (int i = 1; i < vkc_pkg::PIPE_YUV; i++) pipe_ff[i] <= pipe_ff[i-1];
      end
    end
  end
  // shorter path for rgb
  assign tap = (video_format_sel == vkc_pkg::FMT_RGB565) ? pipe_ff[vkc_pkg::PIPE_RGB-1]
                                                         : pipe_ff[vkc_pkg::PIPE_YUV-1];

  // pins cannot stall, so a full buffer shows on video_accept_out
  vkc_fifo #(.WIDTH(vkc_pkg::WORD_W), .DEPTH(vkc_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .in_data_in    (tap[15:0]),
    .in_valid_in   (push_ff & tap[16]),
    .in_ready_out  (video_accept_out),
    .out_data_out  (dac_word_out),
    .out_valid_out (dac_valid_out),
    .out_ready_in  (dac_ready_in)
  );

  // pixel colour key compare
  logic [1:0] phase_ff;
  logic [1:0] last_phase;
  logic       acc_ff, pix_key_ff, take, eq, reserved;
  assign eq       = pix_s == color_key_value;
  assign take     = pclk_rise | (pclk_fall && key_mode_sel == vkc_pkg::KM_PIX16_2E);
  assign reserved = key_mode_sel != vkc_pkg::KM_EXT && !key_mode_sel[2];
  always_comb begin
    case (key_mode_sel)
      vkc_pkg::KM_PIX16_2E, vkc_pkg::KM_PIX16_1E: last_phase = 2'h1;
      vkc_pkg::KM_PIX24:                          last_phase = 2'h2;
      default:                                    last_phase = 2'h0;
    endcase
  end

  // href start realigns byte phase
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_ff   <= 2'h0;
      acc_ff     <= 1'b0;
      pix_key_ff <= 1'b0;
    end else if (href_s & ~href_q_ff) begin
      phase_ff <= 2'h0;
    end else if (take) begin
      if (phase_ff >= last_phase) begin
        pix_key_ff <= eq & (phase_ff == 2'h0 | acc_ff);
        phase_ff   <= 2'h0;
      end else begin
        acc_ff   <= eq & (phase_ff == 2'h0 | acc_ff);
        phase_ff <= phase_ff + 2'h1;
      end
    end
  end

  // key delay line on pixel clock
  logic       key_src;
  logic [6:0] kdly_ff;
  logic       key_tap;
  logic       mix_ff;
  assign key_src = (key_mode_sel == vkc_pkg::KM_EXT) ? ekey_s : pix_key_ff;
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      kdly_ff <= 7'h00;
    end else if (pclk_rise) begin
      kdly_ff <= {kdly_ff[5:0], key_src};
    end
  end
  assign key_tap = (key_delay_cycles == 3'h0) ? key_src : kdly_ff[key_delay_cycles - 3'h1];

  // mixer select; reserved modes fall back to converters
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mix_ff <= 1'b0;
    end else if (!key_gate_on || reserved) begin
      mix_ff <= 1'b0;
    end else if (key_polarity_sel) begin
      mix_ff <= key_tap;
    end else begin
      mix_ff <= ~key_tap;
    end
  end
  assign mixer_sel_ext_out = mix_ff;
endmodule : vkc_top

`default_nettype wire

// ===== vkc_pkg.sv
`default_nettype none
package vkc_pkg;
  // bus address, subaddresses and register reset value
  localparam logic [6:0] I2C_ADDR      = 7'h5F;
  localparam logic [7:0] SUB_MODE      = 8'h00;
  localparam logic [7:0] SUB_DELAY     = 8'h01;
  localparam logic [7:0] SUB_KEY       = 8'h02;
  localparam logic [7:0] REG_RESET     = 8'h00;
  // mode_format_control fields
  localparam int FMT_LSB   = 0;
  localparam int POL_BIT   = 2;
  localparam int GATE_BIT  = 3;
  localparam int CHROMA_BIT = 4;
  localparam int KMODE_LSB = 5;
  // key_delay_control field
  localparam int DELAY_LSB = 0;
  localparam logic [7:0] DELAY_MASK    = 8'h07;
  // video formats
  localparam logic [1:0] FMT_YUV422    = 2'h0;
  localparam logic [1:0] FMT_YUV411    = 2'h1;
  localparam logic [1:0] FMT_YUV211    = 2'h2;
  localparam logic [1:0] FMT_RGB565    = 2'h3;
  // keying modes
  localparam logic [2:0] KM_EXT        = 3'h0;
  localparam logic [2:0] KM_PIX8       = 3'h4;
  localparam logic [2:0] KM_PIX16_2E   = 3'h5;
  localparam logic [2:0] KM_PIX16_1E   = 3'h6;
  localparam logic [2:0] KM_PIX24      = 3'h7;
  // pipeline depth in video clock cycles, buffer depth in words and word width
  localparam int PIPE_YUV  = 20;
  localparam int PIPE_RGB  = 12;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W    = 16;
  // bus controller states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_ADDR = 8'h02, ST_ACKA = 8'h04, ST_SUB  = 8'h08,
    ST_ACKS = 8'h10, ST_DATA = 8'h20, ST_ACKD = 8'h40, ST_SKIP = 8'h80
  } vkc_state_t;
endpackage : vkc_pkg
`default_nettype wire

// ===== vkc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module vkc_properties (
  // clock and resets
  input wire logic        sys_clk_in,
  input wire logic        reset_in,
  input wire logic        control_clear_n_in,
  // serial bus
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_out,
  // keying and video
  input wire logic        pixel_clock_in,
  input wire logic [15:0] dac_word_out,
  input wire logic        dac_valid_out,
  input wire logic        dac_ready_in,
  input wire logic        video_accept_out,
  input wire logic [1:0]  video_format_sel_out,
  input wire logic        mixer_sel_ext_out
);
  logic       pclk_d_ff;
  logic [3:0] pclk_age_ff;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // age of last pixel clock rise; saturates so it never wraps
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pclk_d_ff   <= 1'b0;
      pclk_age_ff <= 4'hF;
    end else begin
      pclk_d_ff <= pixel_clock_in;
      if (pixel_clock_in && !pclk_d_ff) pclk_age_ff <= 4'h0;
      else if (pclk_age_ff != 4'hF) pclk_age_ff <= pclk_age_ff + 4'h1;
    end
  end
  // ack begins; clear pin held
  sequence ack_start;
    $rose(sda_oe_out);
  endsequence
  sequence clear_held;
    !control_clear_n_in [*6];
  endsequence
  AST_ACK_SCL_LOW: assert property (ack_start |-> !scl_in)
    else $error("ack raised while bus clock high");
  AST_ACK_STEADY: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data line moved while bus clock high");
  AST_OPEN_DRAIN: assert property (sda_oe_out |-> !sda_out)
    else $error("data line driven high");
  AST_ACK_WIDTH: assert property (ack_start |=> sda_oe_out [*8])
    else $error("ack too short");
  AST_FIFO_HOLD: assert property (dac_valid_out && !dac_ready_in |=>
    dac_valid_out && $stable(dac_word_out))
    else $error("head word lost while stalled");
  AST_EMPTY_ROOM: assert property (!dac_valid_out |-> video_accept_out)
    else $error("empty buffer refuses words");
  AST_FMT_AT_PCLK: assert property ($changed(video_format_sel_out) && control_clear_n_in
    |-> pclk_age_ff <= 4'h8)
    else $error("format changed away from a pixel clock edge");
  AST_CLEAR_FMT: assert property (clear_held |-> video_format_sel_out == 2'h0)
    else $error("clear pin left format set");
  AST_RESET_STATE: assert property ($fell(reset_in) |-> !sda_oe_out && !mixer_sel_ext_out
    && !dac_valid_out && video_accept_out && video_format_sel_out == 2'h0)
    else $error("outputs not in reset state");
endmodule : vkc_properties
bind vkc_top vkc_properties u_props (.sys_clk_in, .reset_in, .control_clear_n_in, .scl_in,
  .sda_out, .sda_oe_out, .pixel_clock_in, .dac_word_out, .dac_valid_out, .dac_ready_in,
  .video_accept_out, .video_format_sel_out, .mixer_sel_ext_out);
`default_nettype wire

// ===== vkc_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module vkc_i2c_master (
  // system clock and wired data line
  input  wire logic sys_clk_in,
  input  wire logic sda_in,
  // bus clock and data pull-down
  output logic      scl_out,
  output logic      sda_low_out
);
  // idle bus: clock high, data left to its pull-up
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // a quarter of the 160 ns bus period
  task automatic quarter();
    repeat (10) @(negedge sys_clk_in);
  endtask : quarter
  // data moves only while the clock is low, sampled mid high phase
  task automatic put_bit(input logic b, output logic seen);
    sda_low_out = !b;
    quarter();
    scl_out = 1'b1;
    quarter();
    seen = sda_in;
    quarter();
    scl_out = 1'b0;
    quarter();
  endtask : put_bit
  // start, address, subaddress, data, stop; ack[2] is the address byte
  task automatic send(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d,
                      output logic [2:0] ack);
    logic [23:0] fr;
    logic        b;
    fr = {a, s, d};
    sda_low_out = 1'b1;
    quarter();
    scl_out = 1'b0;
    quarter();
    for (int i = 23; i >= 0; i--) begin
      put_bit(fr[i], b);
      if (i % 8 == 0) begin
        put_bit(1'b1, b);
        ack[i / 8] = !b;
      end
    end
    sda_low_out = 1'b1;
    quarter();
    scl_out = 1'b1;
    quarter();
    sda_low_out = 1'b0;
    quarter();
  endtask : send
endmodule : vkc_i2c_master
`default_nettype wire

// ===== vkc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  num_checks++; \
  if ((got) !== (ex)) begin \
    failures++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); \
  end \
end
module vkc_top_tb;
  localparam logic [7:0] AW = {vkc_pkg::I2C_ADDR, 1'b0};
  logic        sys_clk_in = 1'b0, reset_in = 1'b1, control_clear_n_in = 1'b1;
  logic        scl_in, sda_low, sda_in, sda_out, sda_oe_out;
  logic        video_sample_clock_in = 1'b0, href_in = 1'b0, pixel_clock_in = 1'b0;
  logic        external_key_in = 1'b0, dac_ready_in = 1'b0;
  logic [7:0]  yuv_in = 8'h00, uv_in = 8'h00, pixel_in = 8'h00;
  logic [15:0] dac_word_out, exp_w;
  logic        dac_valid_out, video_accept_out, mixer_sel_ext_out;
  logic [1:0]  video_format_sel_out;
  logic [31:0] rnd = 32'h57F11140;
  logic [7:0]  m_ctl = 8'h00, m_dly = 8'h00, m_key = 8'h00;
  int          failures = 0, num_checks = 0, vrise = 0, st = 0, cyc = 0;
  logic [15:0] exp_q[$];
  always #2 sys_clk_in = !sys_clk_in;
  // side clocks move on the falling edge; pixel clock never stops
  always @(negedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7) video_sample_clock_in <= !video_sample_clock_in;
    if (cyc % 10 == 9) pixel_clock_in <= !pixel_clock_in;
  end
  always @(posedge video_sample_clock_in) vrise++;
  // open-drain data line with pull-up
  assign sda_in = !(sda_low || (sda_oe_out && !sda_out));
  vkc_i2c_master mst (.sys_clk_in, .sda_in, .scl_out(scl_in), .sda_low_out(sda_low));
  vkc_top uut (.sys_clk_in, .reset_in, .control_clear_n_in, .scl_in, .sda_in, .sda_out,
    .sda_oe_out, .video_sample_clock_in, .href_in, .yuv_in, .uv_in, .pixel_clock_in,
    .pixel_in, .external_key_in, .dac_word_out, .dac_valid_out, .dac_ready_in,
    .video_accept_out, .video_format_sel_out, .mixer_sel_ext_out);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  // one write; the model keeps only what the device should accept
  task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d);
    logic [2:0] ack;
    mst.send(a, s, d, ack);
    `CHK("ack", (a == AW) ? 3'h7 : 3'h0, ack)
    if (a == AW && s == vkc_pkg::SUB_MODE) m_ctl = d;
    if (a == AW && s == vkc_pkg::SUB_DELAY) m_dly = d & vkc_pkg::DELAY_MASK;
    if (a == AW && s == vkc_pkg::SUB_KEY) m_key = d;
    repeat (40) @(negedge sys_clk_in);
    `CHK("fmt", m_ctl[1:0], video_format_sel_out)
  endtask : wr
  // set key inputs, wait out the delay line, compare mixer
  task automatic key_chk(input logic k, input logic [7:0] p, input int w);
    logic [2:0] md;
    logic       e;
    external_key_in = k;
    pixel_in = p;
    repeat (w) @(negedge sys_clk_in);
    md = m_ctl[7:5];
    e = (md == vkc_pkg::KM_EXT) ? k : (md[2] && p == m_key);
    `CHK("mixer", m_ctl[3] && (md[2] || md == 3'h0) && e == m_ctl[2], mixer_sel_ext_out)
  endtask : key_chk
  // n words; only the first eight fit while the drain stalls
  task automatic vid(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge video_sample_clock_in);
      rnd = xs(rnd);
      href_in = 1'b1;
      {uv_in, yuv_in} = rnd[15:0];
      if (i == 0) st = vrise;
      exp_w = {uv_in, yuv_in};
      if (!m_ctl[4] && m_ctl[1:0] != vkc_pkg::FMT_RGB565) exp_w[15] = !exp_w[15];
      if (i < vkc_pkg::FIFO_DEPTH) exp_q.push_back(exp_w);
    end
    @(negedge video_sample_clock_in);
    href_in = 1'b0;
  endtask : vid
  // pop one word at a time, stalling in between
  task automatic drain();
    while (exp_q.size() > 0) begin
      for (int t = 0; t < 400 && dac_valid_out !== 1'b1; t++) @(negedge sys_clk_in);
      `CHK("valid", 1'b1, dac_valid_out)
      exp_w = exp_q.pop_front();
      `CHK("word", exp_w, dac_word_out)
      dac_ready_in = 1'b1;
      @(negedge sys_clk_in);
      dac_ready_in = 1'b0;
      @(negedge sys_clk_in);
    end
    `CHK("empty", 1'b0, dac_valid_out)
  endtask : drain
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    `CHK("rst fmt", 2'h0, video_format_sel_out)
    for (int f = 0; f < 4; f++) wr(AW, vkc_pkg::SUB_MODE, 8'(f));
    wr(8'h3E, vkc_pkg::SUB_MODE, 8'h01);
    wr(AW | 8'h01, vkc_pkg::SUB_MODE, 8'h02);
    wr(AW, 8'h03, 8'h01);
    $display("done bus");
    rnd = xs(rnd);
    wr(AW, vkc_pkg::SUB_KEY, rnd[7:0]);
    wr(AW, vkc_pkg::SUB_DELAY, 8'h00);
    wr(AW, vkc_pkg::SUB_MODE, 8'h04);
    key_chk(1'b1, m_key, 80);
    for (int c = 0; c < 4; c++) begin
      wr(AW, vkc_pkg::SUB_MODE, {5'h01, c[0], 2'h0});
      key_chk(c[1], 8'h00, 80);
    end
    // reserved code first, then every compare mode
    for (int m = 3; m < 8; m++) begin
      wr(AW, vkc_pkg::SUB_MODE, {m[2:0], 5'h0C});
      key_chk(1'b0, m_key, 120);
      key_chk(1'b1, m_key ^ 8'h40, 120);
    end
    // bytes alternate hit and miss; one repeated byte swaps the pairing
    wr(AW, vkc_pkg::SUB_MODE, 8'hCC);
    for (int i = 0; i < 25; i++) begin
      @(negedge pixel_clock_in);
      pixel_in = m_key ^ {i[0] ^ (i > 11), 7'h00};
      if (i == 11 || i == 24) `CHK("half", 1'b0, mixer_sel_ext_out)
    end
    wr(AW, vkc_pkg::SUB_MODE, 8'h0C);
    wr(AW, vkc_pkg::SUB_DELAY, 8'h07);
    key_chk(1'b0, 8'h00, 200);
    external_key_in = 1'b1;
    repeat (100) @(negedge sys_clk_in);
    `CHK("delay", 1'b0, mixer_sel_ext_out)
    key_chk(1'b1, 8'h00, 120);
    $display("done key");
    wr(AW, vkc_pkg::SUB_MODE, 8'h0F);
    control_clear_n_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    control_clear_n_in = 1'b1;
    m_ctl = 8'h00;
    m_dly = 8'h00;
    m_key = 8'h00;
    key_chk(1'b1, 8'h00, 200);
    `CHK("clear fmt", 2'h0, video_format_sel_out)
    $display("done clear");
    wr(AW, vkc_pkg::SUB_MODE, 8'h00);
    for (int r = 0; r < 2; r++) begin
      vid(1);
      for (int t = 0; t < 800 && dac_valid_out !== 1'b1; t++) @(negedge sys_clk_in);
      `CHK("latency", r ? vkc_pkg::PIPE_RGB : vkc_pkg::PIPE_YUV, vrise - st)
      drain();
      wr(AW, vkc_pkg::SUB_MODE, 8'h03);
    end
    wr(AW, vkc_pkg::SUB_MODE, 8'h11);
    vid(11);
    repeat (400) @(negedge sys_clk_in);
    `CHK("full", 1'b0, video_accept_out)
    drain();
    `CHK("room", 1'b1, video_accept_out)
    $display("done video");
    wrap_up();
  end
  // cut a hang short
  initial begin
    repeat (80000) @(posedge sys_clk_in);
    failures++;
    wrap_up();
  end
endmodule : vkc_top_tb
`default_nettype wire
